/* inc/dsw_pkg.sv */
// Purpose: Shared constants for the serial word loader
// Assumes: Word of 16 bits, 12-bit two's complement code in low bits
// Notes:   No software registers
package dsw_pkg;
  localparam int WORD_BITS   = 16;
  localparam int CODE_BITS   = 12;
  localparam int IGNORE_BITS = 4;
  localparam int CNT_BITS    = 5;
  localparam logic [4:0]  CNT_FULL    = 5'h10;
  localparam logic [11:0] CODE_RESET  = 12'h000;
  localparam int FIFO_DEPTH  = 16;
  localparam int SYNC_STAGES = 2;
endpackage : dsw_pkg

/* hdl/dsw_fifo.sv */
// Purpose: Synchronous FIFO with valid and ready on both sides
// Assumes: Single clock, power of two depth
// Notes:   Read data comes from a register
`timescale 1ns/1ps
module dsw_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // Write side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Read side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg, wr_ptr_next;
  logic [AW:0]      rd_ptr_reg, rd_ptr_next;
  logic             oval_reg,   oval_next;
  logic [WIDTH-1:0] odat_reg,   odat_next;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // ==========================================
  // Pointers and output stage
  assign full      = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
  assign empty     = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready  = !full;
  assign push      = in_valid && !full;
  // Output register refills when drained or empty
  assign pop       = !empty && (!oval_reg || out_ready);
  assign out_valid = oval_reg;
  assign out_data  = odat_reg;

  always_comb begin
    wr_ptr_next = wr_ptr_reg + (push ? 1'b1 : 1'b0);
    rd_ptr_next = rd_ptr_reg + (pop ? 1'b1 : 1'b0);
    oval_next   = oval_reg;
    odat_next   = odat_reg;
    if (pop) begin
      oval_next = 1'b1;
      odat_next = mem_reg[rd_ptr_reg[AW-1:0]];
    end else if (out_ready) begin
      oval_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      oval_reg   <= 1'b0;
      odat_reg   <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      oval_reg   <= oval_next;
      odat_reg   <= odat_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule : dsw_fifo

/* hdl/dsw_loader.sv */
// Purpose: Serial input logic of a 12-bit converter latch
// Assumes: Link pins are asynchronous and sampled by sys_clk
// Notes:   Link clock must be well below sys_clk / 4
//          A new frame drops a manual word never loaded
`timescale 1ns/1ps
module dsw_loader #(
  parameter int FIFO_DEPTH = dsw_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Serial link pins
  input  wire logic        serial_clock,
  input  wire logic        serial_data_input,
  input  wire logic        frame_n,
  input  wire logic        latch_load_n,
  // Converter side
  output logic      [11:0] dac_code,
  output logic             dac_update,
  output logic             auto_mode,
  output logic             word_ready
);
  localparam int CB = dsw_pkg::CODE_BITS;
  localparam int WB = dsw_pkg::WORD_BITS;
  localparam int NB = dsw_pkg::CNT_BITS;

  // ==========================================
  // Pin synchronisers
  // only the host-driven link pins enter here
  // Bit order: load, frame, data, clock
  localparam int NPIN = 4;
  // Reset to idle levels so no false edge follows reset
  localparam logic [NPIN-1:0] PIN_IDLE = 4'hC;
  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] meta_reg, meta_next;
  logic [NPIN-1:0] sync_reg, sync_next;
  logic [NPIN-1:0] last_reg, last_next;
  logic [NPIN-1:0] pin_fall;
  logic            sclk_fall;
  logic            frm_fall;
  logic            ld_fall;
  logic            serial_data_input_lvl;
  logic            frm_lvl;
  logic            ld_lvl;

  assign pin_in = {latch_load_n, frame_n, serial_data_input, serial_clock};

  always_comb begin
    meta_next = pin_in;
    // Levels are read from the second stage; edges compare the second and third
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta_reg <= PIN_IDLE;
      sync_reg <= PIN_IDLE;
      last_reg <= PIN_IDLE;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  // ==========================================
  // Edge detection on synchronised levels
  // Falling edges only: shift, frame start and load act on them
  generate
    for (genvar gp = 0; gp < NPIN; gp++) begin : g_fall
      assign pin_fall[gp] = last_reg[gp] && !sync_reg[gp];
    end
  endgenerate

  assign sclk_fall = pin_fall[0];
  assign frm_fall  = pin_fall[2];
  assign ld_fall   = pin_fall[3];
  assign serial_data_input_lvl  = sync_reg[1];
  assign frm_lvl   = sync_reg[2];
  assign ld_lvl    = sync_reg[3];

  // ==========================================
  // Shift register and bit counter
  logic [WB-1:0] shift_reg, shift_next;
  logic [NB-1:0] cnt_reg,   cnt_next;
  logic          auto_reg,  auto_next;
  logic          full_reg,  full_next;
  logic          push;

  always_comb begin
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    auto_next  = auto_reg;
    full_next  = full_reg;
    push       = 1'b0;
    if (frm_fall) begin
      // sample load level at frame start
      auto_next = !ld_lvl;
      cnt_next  = 5'h00;
      full_next = 1'b0;
    end else if (!frm_lvl && sclk_fall && cnt_reg != dsw_pkg::CNT_FULL) begin
      // shift in on falling clock edge
      shift_next = {shift_reg[WB-2:0], serial_data_input_lvl};
      cnt_next   = cnt_reg + 5'h01;
      if (cnt_reg == dsw_pkg::CNT_FULL - 5'h01) begin
        full_next = 1'b1;
        push      = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      shift_reg <= 16'h0000;
      // Saturated count ignores edges before the first frame
      cnt_reg   <= dsw_pkg::CNT_FULL;
      auto_reg  <= 1'b0;
      full_reg  <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      auto_reg  <= auto_next;
      full_reg  <= full_next;
    end
  end

  // ==========================================
  // Word buffer between shifter and latch
  // Full FIFO drops word; host pacing keeps it shallow
  logic          fifo_in_ready;
  logic          fifo_valid;
  logic [CB-1:0] fifo_data;
  logic          take;
  logic          fifo_in_valid;
  logic [CB-1:0] fifo_in_data;

  // Gate on ready so a dropped word is never offered
  assign fifo_in_valid = push && fifo_in_ready;
  assign fifo_in_data  = shift_next[CB-1:0];

  dsw_fifo #(
    .WIDTH (CB),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_valid),
    .out_ready (take),
    .out_data  (fifo_data)
  );

  // ==========================================
  // Converter latch
  logic [CB-1:0] code_reg, code_next;
  logic          upd_reg,  upd_next;
  logic          rdy_reg,  rdy_next;
  logic          auto_load;
  logic          man_load;
  logic          stale_drop;

  assign auto_load  = fifo_valid && auto_reg;
  // manual update on load fall after full word
  assign man_load   = fifo_valid && !auto_reg && ld_fall && full_reg;
  // Stale unloaded word discarded by a new frame
  assign stale_drop = fifo_valid && !auto_reg && frm_fall;

  always_comb begin
    code_next = code_reg;
    upd_next  = 1'b0;
    take      = 1'b0;
    if (auto_load || man_load) begin
      take      = 1'b1;
      code_next = fifo_data;
      upd_next  = 1'b1;
    end else if (stale_drop) begin
      take = 1'b1;
    end
    rdy_next = fifo_valid && !take;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      code_reg <= dsw_pkg::CODE_RESET;
      upd_reg  <= 1'b0;
      rdy_reg  <= 1'b0;
    end else begin
      code_reg <= code_next;
      upd_reg  <= upd_next;
      rdy_reg  <= rdy_next;
    end
  end

  assign dac_code   = code_reg;
  assign dac_update = upd_reg;
  assign auto_mode  = auto_reg;
  assign word_ready = rdy_reg;
endmodule : dsw_loader

/* bench/dsw_loader_asserts.sv */
// Purpose: Port checks for dsw_loader
// Assumes: Pins reach the logic within 3 sys_clk
// Notes:   Delay windows allow for the synchronizers
`timescale 1ns/1ps
module dsw_loader_asserts (
  // Clock, reset and pins
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        frame_n,
  input wire logic        latch_load_n,
  // Converter side
  input wire logic [11:0] dac_code,
  input wire logic        dac_update,
  input wire logic        auto_mode,
  input wire logic        word_ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ==========================================
  // Mode selection at frame start
  sequence s_fall_auto; ($fell(frame_n) && !latch_load_n) ##1 !latch_load_n [*5]; endsequence
  sequence s_fall_man; ($fell(frame_n) && latch_load_n) ##1 latch_load_n [*5]; endsequence
  a_mode_auto: assert property (s_fall_auto |-> auto_mode) else $error("auto mode missed");
  a_mode_man: assert property (s_fall_man |-> !auto_mode) else $error("manual mode missed");
  a_ready_man: assert property (word_ready |-> !auto_mode) else $error("ready in auto mode");
  a_frame_drop: assert property ($fell(frame_n) |-> ##[1:6] !word_ready) else $error("stale word");
  // ==========================================
  // Latch updates
  a_code_holds: assert property ($changed(dac_code) |-> dac_update) else $error("code moved");
  a_pulse_one: assert property (dac_update |=> !dac_update) else $error("long update");
  a_upd_load: assert property (dac_update |-> !latch_load_n) else $error("update, load high");
  a_no_man_upd: assert property ((latch_load_n && !auto_mode) [*8] |-> !dac_update)
    else $error("manual update without load");
  a_load_upd: assert property (($fell(latch_load_n) && word_ready) |-> ##[3:8] dac_update)
    else $error("load ignored");
endmodule : dsw_loader_asserts
bind dsw_loader dsw_loader_asserts u_dsw_loader_asserts (.sys_clk, .rstn, .frame_n, .latch_load_n,
  .dac_code, .dac_update, .auto_mode, .word_ready);

/* bench/dsw_host.sv */
// Purpose: Serial host driving the loader pins
// Assumes: Link clock period 64 ns
// Notes:   Clock stands low between frames
`timescale 1ns/1ps
module dsw_host (
  // Link pins
  output logic serial_clock,
  output logic serial_data_input,
  output logic frame_n,
  output logic latch_load_n
);
  initial begin
    serial_clock = 1'b0;
    serial_data_input = 1'b0;
    frame_n = 1'b1;
    latch_load_n = 1'b1;
  end
  // ==========================================
  // frame, MSB first
  task send(input logic [15:0] w, input int n);
    int i;
    frame_n = 1'b0;
    #40;
    for (i = 0; i < n; i++) begin
      serial_clock = 1'b1;
      serial_data_input = w[15 - (i % 16)];
      #32 serial_clock = 1'b0;
      #32;
      if (i == 7) #200;
    end
    #40 frame_n = 1'b1;
    // Released line shows no stale bit
    serial_data_input = ~serial_data_input;
  endtask : send
  task pulse_load;
    latch_load_n = 1'b0;
    #60 latch_load_n = 1'b1;
  endtask : pulse_load
  task set_load(input logic v);
    latch_load_n = v;
  endtask : set_load
endmodule : dsw_host

/* bench/tb_dsw_loader.sv */
// Purpose: Self-checking bench for dsw_loader
// Assumes: Updates land within 30 cycles of frame end
// Notes:   Update pulses are counted
`timescale 1ns/1ps
module tb_dsw_loader;
  logic        sys_clk, rstn, serial_clock, serial_data_input, frame_n, latch_load_n;
  logic [11:0] dac_code;
  logic        dac_update, auto_mode, word_ready;
  int          failures, tests_run, upd_cnt, cyc, b;
  dsw_loader #(.FIFO_DEPTH(16)) u_dsw_loader (.sys_clk(sys_clk), .rstn(rstn), .serial_clock(serial_clock),
    .serial_data_input(serial_data_input), .frame_n(frame_n), .latch_load_n(latch_load_n),
    .dac_code(dac_code), .dac_update(dac_update), .auto_mode(auto_mode), .word_ready(word_ready));
  dsw_host u_dsw_host (.serial_clock(serial_clock), .serial_data_input(serial_data_input),
    .frame_n(frame_n), .latch_load_n(latch_load_n));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ==========================================
  // Pulse count and hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (dac_update === 1'b1) upd_cnt <= upd_cnt + 1;
    if (cyc == 10000) begin
      failures++;
      tally_and_finish();
    end
  end
  task settle;
    repeat (30) @(posedge sys_clk);
    #1;
  endtask : settle
  task chk(input logic [11:0] exp, input int n, input logic rdy, input logic am);
    tests_run++;
    if (dac_code !== exp || upd_cnt != n || word_ready !== rdy || auto_mode !== am) begin
      failures++;
      $display("mismatch at %0t: code %h updates %0d mode %b", $time, dac_code, upd_cnt, auto_mode);
    end
  endtask : chk
  // ==========================================
  // Scenarios
  task t_auto;
    logic [11:0] codes [5] = '{12'h7FF, 12'h001, 12'h000, 12'hFFF, 12'h800};
    int k;
    b = upd_cnt;
    u_dsw_host.set_load(1'b0);
    for (k = 0; k < 5; k++) begin
      u_dsw_host.send({4'(k * 5 + 3), codes[k]}, 16);
      settle();
      chk(codes[k], b + k + 1, 1'b0, 1'b1);
    end
    // Offset binary 12'hC00 sent with its top bit flipped
    u_dsw_host.send({4'hA, 12'hC00 ^ 12'h800}, 16);
    settle();
    chk(12'h400, b + 6, 1'b0, 1'b1);
    $display("auto update done");
  endtask : t_auto
  task t_extra;
    b = upd_cnt;
    u_dsw_host.send(16'h0ABC, 21);
    settle();
    chk(12'hABC, b + 1, 1'b0, 1'b1);
    $display("extra edges done");
  endtask : t_extra
  task t_manual;
    b = upd_cnt;
    u_dsw_host.set_load(1'b1);
    u_dsw_host.send(16'hF456, 16);
    settle();
    chk(12'hABC, b, 1'b1, 1'b0);
    // Second frame drops the word never loaded
    u_dsw_host.send(16'h5321, 16);
    settle();
    chk(12'hABC, b, 1'b1, 1'b0);
    u_dsw_host.pulse_load();
    settle();
    chk(12'h321, b + 1, 1'b0, 1'b0);
    u_dsw_host.pulse_load();
    settle();
    chk(12'h321, b + 1, 1'b0, 1'b0);
    $display("manual update done");
  endtask : t_manual
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial begin
    rstn = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 rstn = 1'b1;
    settle();
    chk(12'h000, 0, 1'b0, 1'b0);
    t_auto();
    t_extra();
    t_manual();
    tally_and_finish();
  end
endmodule : tb_dsw_loader
